// ==== src/plc_pkg.sv ====
// constants for the pll divider configuration register slice
package plc_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int NUM_REGS = 7;

  // register offsets on the control port
  localparam logic [9:0] OFS_PLL_CONTROL = 10'h010;
  localparam logic [9:0] OFS_REF_DIV_LOW = 10'h011;
  localparam logic [9:0] OFS_REF_DIV_HIGH = 10'h012;
  localparam logic [9:0] OFS_SWALLOW = 10'h013;
  localparam logic [9:0] OFS_MAIN_LOW = 10'h014;
  localparam logic [9:0] OFS_MAIN_HIGH = 10'h015;
  localparam logic [9:0] OFS_PUMP_CONTROL = 10'h016;

  // values after reset
  localparam logic [7:0] RST_PLL_CONTROL = 8'h0D;
  localparam logic [7:0] RST_REF_DIV_LOW = 8'h01;
  localparam logic [7:0] RST_REF_DIV_HIGH = 8'h00;
  localparam logic [7:0] RST_SWALLOW = 8'h00;
  localparam logic [7:0] RST_MAIN_LOW = 8'h03;
  localparam logic [7:0] RST_MAIN_HIGH = 8'h00;
  localparam logic [7:0] RST_PUMP_CONTROL = 8'h00;

  // implemented bits; all others store nothing and read zero
  localparam logic [7:0] MSK_PLL_CONTROL = 8'h0F;
  localparam logic [7:0] MSK_FULL = 8'hFF;
  localparam logic [7:0] MSK_SIX = 8'h3F;
  localparam logic [7:0] MSK_FIVE = 8'h1F;
  localparam logic [7:0] MSK_PUMP_CONTROL = 8'h80;

  // field positions
  localparam int MODE_LSB = 2;
  localparam int PDN_LSB = 0;
  localparam int MID_SUPPLY_BIT = 7;

  // register index order used by the bank
  localparam int IDX_PLL_CONTROL = 0;
  localparam int IDX_REF_LOW = 1;
  localparam int IDX_REF_HIGH = 2;
  localparam int IDX_SWALLOW = 3;
  localparam int IDX_MAIN_LOW = 4;
  localparam int IDX_MAIN_HIGH = 5;
  localparam int IDX_PUMP = 6;

  localparam logic [NUM_REGS-1:0][9:0] REG_OFS = {OFS_PUMP_CONTROL, OFS_MAIN_HIGH, OFS_MAIN_LOW,
    OFS_SWALLOW, OFS_REF_DIV_HIGH, OFS_REF_DIV_LOW, OFS_PLL_CONTROL};
  localparam logic [NUM_REGS-1:0][7:0] REG_RST = {RST_PUMP_CONTROL, RST_MAIN_HIGH, RST_MAIN_LOW,
    RST_SWALLOW, RST_REF_DIV_HIGH, RST_REF_DIV_LOW, RST_PLL_CONTROL};
  localparam logic [NUM_REGS-1:0][7:0] REG_MSK = {MSK_PUMP_CONTROL, MSK_FIVE, MSK_FULL,
    MSK_SIX, MSK_SIX, MSK_FULL, MSK_PLL_CONTROL};

  // charge pump mode codes
  typedef enum logic [1:0] {
    PLC_PUMP_HIGH_Z = 2'h0,
    PLC_PUMP_UP     = 2'h1,
    PLC_PUMP_DOWN   = 2'h2,
    PLC_PUMP_NORMAL = 2'h3
  } plc_pump_mode_t;

  // pll power-down codes
  typedef enum logic [1:0] {
    PLC_PDN_RUN    = 2'h0,
    PLC_PDN_ASYNC  = 2'h1,
    PLC_PDN_UNUSED = 2'h2,
    PLC_PDN_SYNC   = 2'h3
  } plc_pdn_mode_t;
endpackage : plc_pkg

// ==== src/plc_reg_cell.sv ====
// one 8-bit configuration register with fixed reset value and store mask
`timescale 1ns/1ps
module plc_reg_cell #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] MASK      = 8'hFF
) (
  input  wire logic       clk,     // system clock
  input  wire logic       rst_b,   // async reset, active low
  input  wire logic       wr_en,   // write strobe for this cell
  input  wire logic [7:0] wr_data, // write data
  output logic      [7:0] q        // stored value, unused bits zero
);
  logic [7:0] q_reg;
  logic [7:0] q_next;

  // masked bits never store, so unused bits always read zero
  assign q_next = wr_en ? (wr_data & MASK) : q_reg;
  assign q      = q_reg;

  // storage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q_reg <= RESET_VAL & MASK;
    end else begin
      q_reg <= q_next;
    end
  end
endmodule : plc_reg_cell

// ==== src/plc_config_regs.sv ====
// pll divider and charge pump configuration register slice
//
// What this block does
// - pump mode code: 00 high-z, 01 up, 10 down, 11 normal; reset normal.
// - power-down code: 00 run, 01 async down (reset), 10 unused, 11 sync down.
// - reference divider is 14 bits; low byte at 0x011, reset 0x01.
// - reference divider upper six bits at 0x012 bits 5:0; reset 0x00.
// - six-bit swallow count at 0x013 bits 5:0; reset zero, upper bits unused.
// - main counter is 13 bits; low byte at 0x014, reset 0x03.
// - main counter upper five bits at 0x015 bits 4:0; reset zero.
// - bit 7 at 0x016 forces the pump output to half supply.
// - mid-supply bit clear hands the pump to its mode code, the reset state.
`timescale 1ns/1ps
module plc_config_regs
  import plc_pkg::*;
(
  input  wire logic        clk,             // 25 MHz system clock
  input  wire logic        rst_b,           // async reset, active low
  input  wire logic [9:0]  reg_addr,        // register offset from serial port
  input  wire logic        reg_wr,          // write strobe, one cycle
  input  wire logic [7:0]  reg_wdata,       // write data
  input  wire logic        reg_rd,          // read strobe, one cycle
  output logic      [7:0]  reg_rdata,       // read data, registered
  output logic             reg_rvalid,      // read data valid pulse
  output logic      [1:0]  charge_pump_mode,// raw pump mode field
  output logic      [1:0]  pll_power_down,  // raw power-down field
  output logic             pll_run,         // pll allowed to run
  output logic             pll_pdn_async,   // asynchronous power-down
  output logic             pll_pdn_sync,    // synchronous power-down
  output logic             pump_high_z,     // pump output tristated
  output logic             pump_force_up,   // pump constantly sourcing
  output logic             pump_force_down, // pump constantly sinking
  output logic             pump_normal,     // pump in normal operation
  output logic             pump_mid_supply, // pump held at pump_supply/2
  output logic      [13:0] ref_divider,     // reference divide value
  output logic      [5:0]  swallow_count,   // feedback swallow count
  output logic      [12:0] main_count       // feedback main count
);
  logic [NUM_REGS-1:0][7:0] cell_q;
  logic [NUM_REGS-1:0]      hit;
  logic [7:0]               rd_mux;
  logic [7:0]               rdata_reg;
  logic                     rvalid_reg;

  // one cell per register; offsets, resets and masks come from tables
  generate
    for (genvar i = 0; i < NUM_REGS; i++) begin : g_cell
      assign hit[i] = (reg_addr == REG_OFS[i]);
      plc_reg_cell #(
        .RESET_VAL (REG_RST[i]),
        .MASK      (REG_MSK[i])
      ) u_cell (
        .clk     (clk),
        .rst_b   (rst_b),
        .wr_en   (reg_wr && hit[i]),
        .wr_data (reg_wdata),
        .q       (cell_q[i])
      );
    end
  endgenerate

  // read select; an unmapped offset reads zero
  always_comb begin
    rd_mux = 8'h00;
    for (int j = 0; j < NUM_REGS; j++) begin
      if (hit[j]) begin
        rd_mux = cell_q[j];
      end
    end
  end

  // read data held until the next read
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= reg_rd;
      if (reg_rd) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  assign reg_rdata  = rdata_reg;
  assign reg_rvalid = rvalid_reg;

  assign charge_pump_mode = cell_q[IDX_PLL_CONTROL][MODE_LSB +: 2];
  assign pll_power_down = cell_q[IDX_PLL_CONTROL][PDN_LSB +: 2];
  assign pll_run        = (pll_power_down == PLC_PDN_RUN);
  assign pll_pdn_async  = (pll_power_down == PLC_PDN_ASYNC);
  assign pll_pdn_sync   = (pll_power_down == PLC_PDN_SYNC);

  assign pump_mid_supply = cell_q[IDX_PUMP][MID_SUPPLY_BIT];

  // mode decode only acts while mid-supply is clear
  // the force wins so the loop filter never sees two drivers at once
  assign pump_high_z     = !pump_mid_supply && (charge_pump_mode == PLC_PUMP_HIGH_Z);
  assign pump_force_up   = !pump_mid_supply && (charge_pump_mode == PLC_PUMP_UP);
  assign pump_force_down = !pump_mid_supply && (charge_pump_mode == PLC_PUMP_DOWN);
  assign pump_normal     = !pump_mid_supply && (charge_pump_mode == PLC_PUMP_NORMAL);

  assign ref_divider = {cell_q[IDX_REF_HIGH][5:0], cell_q[IDX_REF_LOW]};
  assign swallow_count = cell_q[IDX_SWALLOW][5:0];
  assign main_count = {cell_q[IDX_MAIN_HIGH][4:0], cell_q[IDX_MAIN_LOW]};

  a_mode_write_lands: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && reg_addr == OFS_PLL_CONTROL |=> charge_pump_mode == $past(reg_wdata[3:2]))
    else $error("pump mode did not follow write");

  a_pump_up_decode: assert property (@(posedge clk) disable iff (!rst_b)
    !pump_mid_supply && charge_pump_mode == 2'h1
      |-> pump_force_up && !pump_force_down && !pump_normal && !pump_high_z)
    else $error("pump up decode wrong");

  a_pump_down_decode: assert property (@(posedge clk) disable iff (!rst_b)
    !pump_mid_supply && charge_pump_mode == 2'h2
      |-> pump_force_down && !pump_force_up && !pump_normal && !pump_high_z)
    else $error("pump down decode wrong");

  a_high_z_decode: assert property (@(posedge clk) disable iff (!rst_b)
    !pump_mid_supply && charge_pump_mode == 2'h0
      |-> pump_high_z && !pump_force_up && !pump_force_down && !pump_normal)
    else $error("pump high impedance decode wrong");

  a_run_only_zero: assert property (@(posedge clk) disable iff (!rst_b)
    pll_run == (pll_power_down == 2'h0) && !(pll_pdn_async && pll_pdn_sync))
    else $error("pll run decode wrong");

  a_pdn_sync_code: assert property (@(posedge clk) disable iff (!rst_b)
    pll_power_down == 2'h3 |-> pll_pdn_sync && !pll_pdn_async && !pll_run)
    else $error("sync power-down decode wrong");

  a_pdn_unused_stop: assert property (@(posedge clk) disable iff (!rst_b)
    pll_power_down == 2'h2 |-> !pll_run && !pll_pdn_async && !pll_pdn_sync)
    else $error("unused power-down code decode wrong");

  a_ref_low_write: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && reg_addr == OFS_REF_DIV_LOW |=> ref_divider[7:0] == $past(reg_wdata))
    else $error("reference low byte not stored");

  // high byte readback; a write in the read cycle lands after the data is taken
  a_ref_high_mask: assert property (@(posedge clk) disable iff (!rst_b)
    reg_rd && reg_addr == OFS_REF_DIV_HIGH |=> reg_rvalid && reg_rdata[7:6] == 2'h0
      && reg_rdata[5:0] == $past(ref_divider[13:8]))
    else $error("reference high read wrong");

  a_ref_high_join: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && reg_addr == OFS_REF_DIV_HIGH
      |=> ref_divider == {$past(reg_wdata[5:0]), $past(ref_divider[7:0])})
    else $error("reference divider halves not joined");

  a_swallow_write: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && reg_addr == OFS_SWALLOW ##1 !(reg_wr && reg_addr == OFS_SWALLOW) [*2]
      |-> swallow_count == $past(reg_wdata[5:0], 2))
    else $error("swallow count not held");

  a_main_low_write: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && reg_addr == OFS_MAIN_LOW |=> main_count[7:0] == $past(reg_wdata))
    else $error("main low byte not stored");

  a_main_low_join: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && reg_addr == OFS_MAIN_LOW
      |=> main_count == {$past(main_count[12:8]), $past(reg_wdata)})
    else $error("main counter halves not joined");

  a_main_high_mask: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && reg_addr == OFS_MAIN_HIGH |=> main_count[12:8] == $past(reg_wdata[4:0]))
    else $error("main high bits not stored");

  a_mid_supply_set: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && reg_addr == OFS_PUMP_CONTROL && reg_wdata[7] |=> pump_mid_supply && !pump_normal)
    else $error("mid supply force not applied");

  a_mid_clear_norm: assert property (@(posedge clk) disable iff (!rst_b)
    !pump_mid_supply && charge_pump_mode == 2'h3 |-> pump_normal && !pump_high_z)
    else $error("pump not normal with bit clear");

  // clearing bit 7 releases the pump to its mode
  a_mid_clear_write: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && reg_addr == OFS_PUMP_CONTROL && !reg_wdata[7]
      |=> !pump_mid_supply && (pump_normal || pump_high_z || pump_force_up || pump_force_down))
    else $error("pump not released when bit cleared");

  // unmapped offsets read zero
  a_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_b)
    reg_rd && (reg_addr < OFS_PLL_CONTROL || reg_addr > OFS_PUMP_CONTROL) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  // unmapped writes change nothing, so a stray offset cannot retune the loop
  a_unmapped_write: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && (reg_addr < OFS_PLL_CONTROL || reg_addr > OFS_PUMP_CONTROL)
      |=> $stable(ref_divider) && $stable(main_count) && $stable(swallow_count)
        && $stable(charge_pump_mode) && $stable(pll_power_down) && $stable(pump_mid_supply))
    else $error("unmapped write changed a field");

  // read valid echoes the strobe
  a_read_valid_pulse: assert property (@(posedge clk) disable iff (!rst_b)
    reg_rvalid == $past(reg_rd))
    else $error("read valid not one cycle after strobe");

  // read data stands between reads
  a_rdata_holds: assert property (@(posedge clk) disable iff (!rst_b)
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
endmodule : plc_config_regs

// ==== verification/test_plc_config_regs.sv ====
// self-checking bench for the pll divider configuration register slice
`timescale 1ns/1ps
module test_plc_config_regs
  import plc_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [9:0]  reg_addr = 10'h000;
  logic        reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  reg_rdata;
  logic        reg_rvalid, pll_run, pll_pdn_async, pll_pdn_sync;
  logic        pump_high_z, pump_force_up, pump_force_down, pump_normal, pump_mid_supply;
  logic [1:0]  charge_pump_mode, pll_power_down;
  logic [13:0] ref_divider;
  logic [5:0]  swallow_count;
  logic [12:0] main_count;
  logic [7:0]  model [NUM_REGS];
  logic [31:0] seed = 32'hAF77;
  int          mismatches = 0, tests_run = 0, cycles = 0;

  plc_config_regs plc_config_regs_i (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .charge_pump_mode(charge_pump_mode), .pll_power_down(pll_power_down), .pll_run(pll_run),
    .pll_pdn_async(pll_pdn_async), .pll_pdn_sync(pll_pdn_sync), .pump_high_z(pump_high_z),
    .pump_force_up(pump_force_up), .pump_force_down(pump_force_down), .pump_normal(pump_normal),
    .pump_mid_supply(pump_mid_supply), .ref_divider(ref_divider), .swallow_count(swallow_count),
    .main_count(main_count));

  // 25 MHz clock
  always #20 clk = ~clk;

  // cut a hang short; the whole run needs well under 2000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      end_of_test();
    end
  end

  // step the pseudo-random source
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  // index of a mapped offset, -1 when unmapped
  function automatic int find(input logic [9:0] a);
    for (int i = 0; i < NUM_REGS; i++) if (REG_OFS[i] === a) return i;
    return -1;
  endfunction : find

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // compare every field output with the model
  task automatic chk_fields();
    logic mid;
    mid = model[IDX_PUMP][7];
    cmp({charge_pump_mode, pll_power_down}, model[IDX_PLL_CONTROL][3:0]);
    cmp({pll_run, pll_pdn_async, pll_pdn_sync}, {model[0][1:0] == 2'h0, model[0][1:0] == 2'h1,
        model[0][1:0] == 2'h3});
    cmp({ref_divider, swallow_count}, {model[2][5:0], model[1], model[3][5:0]});
    cmp(main_count, {model[5][4:0], model[4]});
    cmp({pump_high_z, pump_force_up, pump_force_down, pump_normal, pump_mid_supply},
        {!mid && model[0][3:2] == 2'h0, !mid && model[0][3:2] == 2'h1, !mid && model[0][3:2] == 2'h2,
         !mid && model[0][3:2] == 2'h3, mid});
  endtask : chk_fields

  // read results: valid flag and data together
  task automatic cmp_read(input logic vld, input logic [7:0] exp);
    cmp({vld, exp}, {vld, exp} ^ {reg_rvalid ^ vld, reg_rdata ^ exp});
  endtask : cmp_read

  // one write; unused bits and unmapped offsets store nothing
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    int i;
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    i = find(a);
    if (i >= 0) model[i] = d & REG_MSK[i];
    chk_fields();
  endtask : wr

  // one read; data and valid are due one cycle after the strobe, then valid drops and data stands
  task automatic rd(input logic [9:0] a);
    int i;
    logic [7:0] exp;
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    i = find(a);
    exp = (i >= 0) ? model[i] : 8'h00;
    @(negedge clk);
    reg_rd = 1'b0;
    cmp_read(1'b1, exp);
    @(negedge clk);
    cmp_read(1'b0, exp);
  endtask : rd

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test

  initial begin
    for (int i = 0; i < NUM_REGS; i++) model[i] = REG_RST[i];
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    // reset values, readback including one unmapped offset
    chk_fields();
    for (int a = 16; a < 24; a++) rd(a[9:0]);
    // every mode and power-down code, with and without the mid-supply force
    for (int c = 0; c < 32; c++) begin
      wr(OFS_PUMP_CONTROL, {c[4], 7'h7F});
      wr(OFS_PLL_CONTROL, {4'hF, c[3:0]});
      rd(OFS_PLL_CONTROL);
    end
    // random traffic, divider bytes, unmapped and far offsets
    for (int n = 0; n < 120; n++) begin
      seed = lfsr(seed);
      wr(seed[9] ? 10'h3FF : 10'h010 + seed[2:0], seed[17:10]);
      rd(10'h010 + seed[5:3]);
    end
    // read and write of one offset in the same cycle: the read returns the old value
    @(negedge clk);
    reg_addr = OFS_SWALLOW;
    reg_wdata = 8'hFF;
    reg_wr = 1'b1;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    cmp_read(1'b1, model[IDX_SWALLOW]);
    model[IDX_SWALLOW] = 8'hFF & REG_MSK[IDX_SWALLOW];
    chk_fields();
    // reset in mid-run brings every register and the read port back
    @(negedge clk);
    rst_b = 1'b0;
    for (int i = 0; i < NUM_REGS; i++) model[i] = REG_RST[i];
    @(negedge clk);
    cmp_read(1'b0, 8'h00);
    chk_fields();
    rst_b = 1'b1;
    rd(OFS_MAIN_LOW);
    rd(OFS_REF_DIV_LOW);
    end_of_test();
  end
endmodule : test_plc_config_regs
